// ===== rtl/pspc_stage.sv
// protection and control logic of the stereo power stage
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module pspc_stage
  import pspc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link to the controller
  pspc_link_if.device link,
  // straps
  input wire logic prot_mode_strap_a,
  input wire logic prot_mode_strap_b,
  input wire logic out_config_strap,
  // analog detector outputs, asynchronous
  input wire logic [PSPC_NSW-1:0] overcurrent_error,
  input wire logic overtemp_warn,
  input wire logic overtemp_error,
  input wire logic gate_supply_low,
  // gate drive, per bridge: high, low, output enable
  output logic [PSPC_NBRIDGE-1:0] gate_high,
  output logic [PSPC_NBRIDGE-1:0] gate_low,
  output logic [PSPC_NBRIDGE-1:0] bridge_drive,
  // decoded state for observation
  output pspc_mode_t prot_mode,
  output logic latch_set,
  output logic btl_config
);
  logic [1:0] rst_s1, rst_s2;
  logic [2:0] strap_s1, strap_s2;
  logic [PSPC_NSW-1:0] ovc_s1, ovc_s2;
  logic [2:0] ot_s1, ot_s2;
  logic reset_hi, reset_hi_d, pwm_d, pwm_rise, fault_any;
  logic hold_hiz;
  logic [PSPC_RCV_W-1:0] rcv_count;
  logic rcv_active;

  // two-stage synchronisers for reset, straps and detectors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_s1 <= 2'h0;
      rst_s2 <= 2'h0;
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
      ovc_s1 <= '0;
      ovc_s2 <= '0;
      ot_s1 <= 3'h0;
      ot_s2 <= 3'h0;
    end else begin
      rst_s1 <= {link.bridge_pair2_reset_n,
                 link.bridge_pair1_reset_n};
      rst_s2 <= rst_s1;
      strap_s1 <= {out_config_strap, prot_mode_strap_b, prot_mode_strap_a};
      strap_s2 <= strap_s1;
      ovc_s1 <= overcurrent_error;
      ovc_s2 <= ovc_s1;
      ot_s1 <= {gate_supply_low, overtemp_error, overtemp_warn};
      ot_s2 <= ot_s1;
    end
  end

  // both reset pins must be high to run; a shared latch covers both
  assign reset_hi = &rst_s2;

  // reserved strap codes fall back to latching, the safest choice
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prot_mode <= PSPC_LATCHING;
      btl_config <= 1'b1;
    end else begin
      if ({strap_s2[0], strap_s2[1]} == PSPC_MODE_LATCH) begin
        prot_mode <= PSPC_LATCHING;
      end else if (strap_s2[1:0] == 2'h3) begin
        prot_mode <= PSPC_PROT_OFF;
      end else if (strap_s2[1:0] == 2'h0) begin
        prot_mode <= PSPC_AUTORECOVER;
      end else begin
        prot_mode <= PSPC_LATCHING;
      end
      btl_config <= (strap_s2[2] == PSPC_CFG_BTL);
    end
  end

  // any switch overcurrent, thermal error or shared lockout
  assign fault_any = (|ovc_s2) | ot_s2[1] | ot_s2[2];

  // pwm edge detect on the first channel's positive input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_d <= 1'b0;
      reset_hi_d <= 1'b0;
    end else begin
      pwm_d <= link.pwm_pos_in[0];
      reset_hi_d <= reset_hi;
    end
  end
  assign pwm_rise = link.pwm_pos_in[0] & ~pwm_d;

  // error latch: set wins; cleared on reset fall or at half count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_set <= 1'b0;
    end else if (prot_mode == PSPC_PROT_OFF) begin
      latch_set <= 1'b0;
    end else if (fault_any && reset_hi) begin
      latch_set <= 1'b1;
    end else if (reset_hi_d && !reset_hi) begin
      latch_set <= 1'b0;
    end else if (rcv_active && pwm_rise &&
                 rcv_count == PSPC_RCV_HALF - 10'h1) begin
      latch_set <= 1'b0;
    end
  end

  // one shared recovery counter for both bridges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rcv_count <= '0;
      rcv_active <= 1'b0;
    end else if (prot_mode != PSPC_AUTORECOVER || !reset_hi) begin
      rcv_count <= '0;
      rcv_active <= 1'b0;
    end else if (!rcv_active) begin
      if (fault_any) begin
        rcv_active <= 1'b1;
        rcv_count <= '0;
      end
    end else if (pwm_rise) begin
      if (rcv_count == PSPC_RCV_FULL - 10'h1) begin
        rcv_active <= fault_any; // restart if still faulty
        rcv_count <= '0;
      end else begin
        rcv_count <= rcv_count + 10'h1;
      end
    end
  end

  // hi-z while muted, latched, or waiting out the recovery count
  assign hold_hiz = !reset_hi || latch_set || rcv_active ||
                    (fault_any && prot_mode != PSPC_PROT_OFF);

  // gate drive follows pwm per bridge only when enabled
  genvar gi;
  generate
    for (gi = 0; gi < PSPC_NBRIDGE; gi++) begin : g_bridge
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          gate_high[gi] <= 1'b0;
          gate_low[gi] <= 1'b0;
          bridge_drive[gi] <= 1'b0;
        end else if (hold_hiz || !btl_config) begin
          gate_high[gi] <= 1'b0;
          gate_low[gi] <= 1'b0;
          bridge_drive[gi] <= 1'b0;
        end else begin
          gate_high[gi] <= link.pwm_pos_in[gi];
          gate_low[gi] <= link.pwm_neg_in[gi];
          bridge_drive[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // open-drain reporting; enable high pulls the pin low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.fault_report_n_oe <= 1'b0;
      link.thermal_warn_n_oe <= 1'b0;
    end else begin
      link.fault_report_n_oe <= reset_hi && latch_set;
      link.thermal_warn_n_oe <= ot_s2[0] | ot_s2[1];
    end
  end
endmodule
`default_nettype wire

// ===== rtl/pspc_pkg.sv
// package of constants and types for the power stage protection control
// Functional notes
// - reset low keeps bridges high impedance
// - controller holds reset low one millisecond
// - release reset only with valid pwm
// - never hold positive pwm constantly high
// - power down: reset low before pwm stops
// - fault low on error, forced high in reset
// - warning low while junction above limit
// - warning and fault jointly encode state
// - any error sets bridges high impedance
// - latch clears on reset fall, resumes high
// - reset low mutes switching without error
// - overcurrent per high and low switch
// - one shared undervoltage lockout detector
// - autorecovery clears at n/2, resumes n
// - one recovery counter for both bridges
// - latching mode holds until reset toggles
// - protection off mode for test only
// - output strap low selects bridge tied
package pspc_pkg;
  // recovery counter length in pwm input cycles
  localparam int unsigned PSPC_RCV_CYCLES = 512;
  localparam int unsigned PSPC_RCV_W = 10;
  localparam logic [PSPC_RCV_W-1:0] PSPC_RCV_FULL = 10'h200;
  localparam logic [PSPC_RCV_W-1:0] PSPC_RCV_HALF = 10'h100;
  // number of half-bridges and of switches in total, two per bridge
  localparam int unsigned PSPC_NBRIDGE = 2;
  localparam int unsigned PSPC_NSW = 2 * PSPC_NBRIDGE;
  // strap encodings
  localparam logic [1:0] PSPC_MODE_LATCH = 2'h1;
  localparam logic PSPC_CFG_BTL = 1'h0;
  // power-up timing kept by the controller
  localparam int unsigned PSPC_CLK_MHZ = 100;
  localparam int unsigned PSPC_CHARGE_US = 1000;
  localparam int unsigned PSPC_CHARGE_CYCLES = PSPC_CHARGE_US * PSPC_CLK_MHZ;
  // pwm half period for 384 khz from 100 mhz, in clock cycles
  localparam int unsigned PSPC_PWM_HALF = 130;
  localparam int unsigned PSPC_PWM_W = 8;
  // register map of the controller, byte addresses
  localparam logic [7:0] PSPC_REG_CTRL = 8'h00;
  localparam logic [7:0] PSPC_REG_STATUS = 8'h04;
  localparam logic [7:0] PSPC_REG_MODE = 8'h08;
  // ctrl fields
  localparam int unsigned PSPC_CTRL_ENABLE = 0;
  localparam int unsigned PSPC_CTRL_PWM_RUN = 1;
  // status fields
  localparam int unsigned PSPC_ST_FAULT = 0;
  localparam int unsigned PSPC_ST_WARN = 1;
  localparam int unsigned PSPC_ST_RESET = 2;
  localparam int unsigned PSPC_ST_PWM = 3;
  localparam int unsigned PSPC_ST_STATE = 4;
  // protection modes decoded from the straps
  typedef enum logic [1:0] {
    PSPC_AUTORECOVER = 2'h0,
    PSPC_LATCHING = 2'h1,
    PSPC_PROT_OFF = 2'h2
  } pspc_mode_t;
  // controller sequencing states, gray along the path
  typedef enum logic [1:0] {
    PSPC_OFF = 2'h0,
    PSPC_PWM_UP = 2'h1,
    PSPC_CHARGE = 2'h3,
    PSPC_RUN = 2'h2
  } pspc_seq_t;
  // joint decoding of warning and fault pins
  function automatic logic [1:0] pspc_report(input logic warn_n,
                                             input logic fault_n);
    return {warn_n, fault_n};
  endfunction
endpackage

// ===== rtl/pspc_link_if.sv
// interface joining the power stage and its controller
`timescale 1ns/100ps
`default_nettype none
interface pspc_link_if;
  logic [1:0] pwm_pos_in;
  logic [1:0] pwm_neg_in;
  logic bridge_pair1_reset_n;
  logic bridge_pair2_reset_n;
  logic fault_report_n_oe;
  logic thermal_warn_n_oe;
  // open-drain wires with pullup resolved here
  logic fault_report_n;
  logic thermal_warn_n;
  assign fault_report_n = ~fault_report_n_oe;
  assign thermal_warn_n = ~thermal_warn_n_oe;
  modport device (
    input pwm_pos_in, pwm_neg_in, bridge_pair1_reset_n,
    input bridge_pair2_reset_n,
    output fault_report_n_oe, thermal_warn_n_oe
  );
  modport host (
    output pwm_pos_in, pwm_neg_in, bridge_pair1_reset_n,
    output bridge_pair2_reset_n,
    input fault_report_n, thermal_warn_n
  );
endinterface
`default_nettype wire

// ===== rtl/pspc_ctrl.sv
// system controller end: pwm source, reset sequencing, ahb-lite registers
`timescale 1ns/100ps
`default_nettype none
module pspc_ctrl
  import pspc_pkg::*;
#(
  parameter int unsigned CHARGE_CYCLES = PSPC_CHARGE_CYCLES,
  parameter int unsigned PWM_HALF = PSPC_PWM_HALF
)(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // link to the power stage
  pspc_link_if.host link
);
  logic [1:0] ctrl;
  logic wr_pend;
  logic [7:0] wr_addr;
  pspc_seq_t seq;
  logic [31:0] wait_cnt;
  logic [PSPC_PWM_W-1:0] pwm_div;
  logic pwm_q;
  logic [1:0] report;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign report = pspc_report(link.thermal_warn_n, link.fault_report_n);

  // address phase capture and reads from registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      wr_addr <= haddr;
      if (hsel && hready && htrans[1] && !hwrite) begin
        unique case (haddr)
          PSPC_REG_CTRL: hrdata <= {30'h0, ctrl};
          PSPC_REG_STATUS: hrdata <= {26'h0, seq, pwm_q,
                                      link.bridge_pair1_reset_n,
                                      ~report[1], ~report[0]};
          PSPC_REG_MODE: hrdata <= {30'h0, report};
          default: hrdata <= 32'h0;
        endcase
      end
    end
  end

  // control register write in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= 2'h0;
    end else if (wr_pend && wr_addr == PSPC_REG_CTRL) begin
      ctrl <= hwdata[1:0];
    end
  end

  // symmetric pwm at about 384 khz; never constant high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_div <= '0;
      pwm_q <= 1'b0;
    end else if (seq == PSPC_OFF) begin
      pwm_div <= '0;
      pwm_q <= 1'b0;
    end else if (pwm_div == PSPC_PWM_W'(PWM_HALF - 1)) begin
      pwm_div <= '0;
      pwm_q <= ~pwm_q;
    end else begin
      pwm_div <= pwm_div + 8'h1;
    end
  end

  // sequencing: pwm up, charge wait, release; reset drops before pwm
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq <= PSPC_OFF;
      wait_cnt <= 32'h0;
    end else begin
      unique case (seq)
        PSPC_OFF: if (ctrl[PSPC_CTRL_ENABLE]) seq <= PSPC_PWM_UP;
        PSPC_PWM_UP: begin
          wait_cnt <= 32'h0;
          seq <= ctrl[PSPC_CTRL_ENABLE] ? PSPC_CHARGE : PSPC_OFF;
        end
        PSPC_CHARGE: begin
          if (!ctrl[PSPC_CTRL_ENABLE]) begin
            seq <= PSPC_OFF;
          end else if (wait_cnt == CHARGE_CYCLES - 1) begin
            seq <= PSPC_RUN;
          end else begin
            wait_cnt <= wait_cnt + 32'h1;
          end
        end
        PSPC_RUN: if (!ctrl[PSPC_CTRL_ENABLE]) seq <= PSPC_PWM_UP;
      endcase
    end
  end

  // drive the link from flops; reset low except in run with the PSPC_CTRL_PWM_RUN bit set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.pwm_pos_in <= 2'h0;
      link.pwm_neg_in <= 2'h0;
      link.bridge_pair1_reset_n <= 1'b0;
      link.bridge_pair2_reset_n <= 1'b0;
    end else begin
      link.pwm_pos_in <= {2{pwm_q}};
      link.pwm_neg_in <= {2{~pwm_q & (seq != PSPC_OFF)}};
      link.bridge_pair1_reset_n <= (seq == PSPC_RUN) &&
                                   ctrl[PSPC_CTRL_PWM_RUN];
      link.bridge_pair2_reset_n <= (seq == PSPC_RUN) &&
                                   ctrl[PSPC_CTRL_PWM_RUN];
    end
  end
endmodule
`default_nettype wire

// ===== testbench/pspc_assertions.sv
// checker on the link between the power stage and its controller
`timescale 1ns/100ps
`default_nettype none
module pspc_assertions #(
  parameter int unsigned CHARGE_CYCLES = 50
)(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link signals
  input wire logic [1:0] pwm_pos_in,
  input wire logic bridge_pair1_reset_n,
  input wire logic fault_report_n,
  input wire logic thermal_warn_n,
  // thermal detector inputs of the stage
  input wire logic overtemp_warn,
  input wire logic overtemp_error
);
  logic [31:0] low_cnt;
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // cycles the bridge reset has stayed low, i.e. bootstrap charge time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      low_cnt <= 32'h0;
    else if (bridge_pair1_reset_n)
      low_cnt <= 32'h0;
    else
      low_cnt <= low_cnt + 32'h1;
  end
  // the stage samples reset through two flops, hence the margins below
  a_fault_in_reset: assert property (!bridge_pair1_reset_n [*5]
    |-> fault_report_n) else $error("fault pin low in reset");
  a_charge_time: assert property ($rose(bridge_pair1_reset_n)
    |-> low_cnt >= CHARGE_CYCLES) else $error("reset released too early");
  a_pwm_at_release: assert property ($rose(bridge_pair1_reset_n)
    |-> ##[0:140] $changed(pwm_pos_in[0])) else $error("no pwm at release");
  a_pwm_not_stuck: assert property ($rose(pwm_pos_in[0])
    |-> ##[1:300] !pwm_pos_in[0]) else $error("pwm stuck high");
  a_pwm_before_off: assert property (bridge_pair1_reset_n
    |-> ##[0:300] (!bridge_pair1_reset_n || $changed(pwm_pos_in[1])))
    else $error("pwm stopped with reset high");
  a_warn_follows: assert property (overtemp_warn [*5]
    |-> !thermal_warn_n) else $error("warning pin not low");
  a_warn_clears: assert property (!(overtemp_warn || overtemp_error) [*5]
    |-> thermal_warn_n) else $error("warning pin not high");
  a_overtemp_joint: assert property ((overtemp_error &&
    bridge_pair1_reset_n) [*7]
    |-> !(fault_report_n || thermal_warn_n))
    else $error("overtemp error not reported on both pins");
  // main scenarios reached
  c_fault: cover property ($fell(fault_report_n));
  c_release: cover property ($rose(bridge_pair1_reset_n));
  c_warn: cover property ($fell(thermal_warn_n));
endmodule
`default_nettype wire

// ===== testbench/pspc_tb_top.sv
// testbench: controller and power stage joined, driven over ahb-lite
`timescale 1ns/100ps
`default_nettype none
module pspc_tb_top;
  import pspc_pkg::*;
  // short charge wait and fast pwm keep the run well under 100k cycles
  localparam int unsigned CHARGE_SIM = 50;
  localparam int unsigned PWM_HALF_SIM = 20;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic strap_a = 1'b0;
  logic strap_b = 1'b1;
  logic cfg_strap = 1'b0;
  logic [3:0] ovc = 4'h0;
  logic ow = 1'b0;
  logic ot_err = 1'b0;
  logic uv = 1'b0;
  logic [1:0] gh;
  logic [1:0] gl;
  logic [1:0] drv;
  pspc_mode_t mode;
  logic latch;
  logic btl;
  int err_total = 0;
  int total_checks = 0;
  int seed = 32'hfc52d389;
  int edges = 0;
  logic [31:0] rd;
  logic [3:0] pwm_seen = 4'h0;
  // model: mode per strap pair, pin pair {warn_n,fault_n} per event
  pspc_mode_t mtab [4] = '{PSPC_AUTORECOVER, PSPC_LATCHING,
                           PSPC_LATCHING, PSPC_PROT_OFF};
  int m_pins [8] = '{2, 2, 2, 2, 2, 0, 1, 3};
  pspc_link_if link();
  pspc_ctrl #(.CHARGE_CYCLES(CHARGE_SIM), .PWM_HALF(PWM_HALF_SIM))
    u_pspc_ctrl (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link(link));
  pspc_stage u_pspc_stage (.hclk(hclk), .hresetn(hresetn), .link(link),
    .prot_mode_strap_a(strap_a), .prot_mode_strap_b(strap_b),
    .out_config_strap(cfg_strap), .overcurrent_error(ovc),
    .overtemp_warn(ow), .overtemp_error(ot_err), .gate_supply_low(uv),
    .gate_high(gh), .gate_low(gl), .bridge_drive(drv), .prot_mode(mode),
    .latch_set(latch), .btl_config(btl));
  pspc_assertions #(.CHARGE_CYCLES(CHARGE_SIM))
    u_pspc_assertions (.hclk(hclk),
    .hresetn(hresetn), .pwm_pos_in(link.pwm_pos_in),
    .bridge_pair1_reset_n(link.bridge_pair1_reset_n),
    .fault_report_n(link.fault_report_n),
    .thermal_warn_n(link.thermal_warn_n), .overtemp_warn(ow),
    .overtemp_error(ot_err));
  // 100 mhz clock
  always #5 hclk = ~hclk;
  // pwm as the stage sampled it at the last edge, to predict its gates
  always @(posedge hclk)
    pwm_seen <= {link.pwm_pos_in, link.pwm_neg_in};
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // an exhausted wait counts as a mismatch and ends the run
  task automatic bad();
    err_total++;
    report_and_stop();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // one edge, then more until the slave is ready
  task automatic rdy();
    int i;
    @(posedge hclk);
    for (i = 0; i < 50 && hreadyout !== 1'b1; i++)
      @(posedge hclk);
    if (i == 50)
      bad();
  endtask
  // single word transfer; read data lands in rd
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask
  task automatic wait_rst(input logic lvl);
    int i;
    for (i = 0; i < 3000 && link.bridge_pair1_reset_n !== lvl; i++)
      @(posedge hclk);
    if (i == 3000)
      bad();
  endtask
  // count pwm rising edges until latch clears (0) or bridges drive (1)
  task automatic count_until(input int what);
    int i;
    logic prev;
    prev = link.pwm_pos_in[0];
    for (i = 0; i < 30000; i++) begin
      @(posedge hclk);
      edges += int'(link.pwm_pos_in[0] && !prev);
      prev = link.pwm_pos_in[0];
      if (what == 0 ? latch === 1'b0 : drv === 2'h3)
        break;
    end
    if (i == 30000)
      bad();
  endtask
  // return at the edge where the stage sees a pwm rising edge
  task automatic wait_rise();
    int i;
    logic prev;
    prev = 1'b1;
    for (i = 0; i < 600; i++) begin
      @(posedge hclk);
      if (link.pwm_pos_in[0] && !prev)
        break;
      prev = link.pwm_pos_in[0];
    end
    if (i == 600)
      bad();
  endtask
  // main sequence
  initial begin
    cyc(10);
    hresetn <= 1'b1;
    cyc(6);
    chk(32'({gh, gl, drv}), 32'h0);
    ahb(1'b0, PSPC_REG_STATUS, 32'h0);
    chk(rd & 32'h37, {26'h0, PSPC_OFF, 4'h0});
    ahb(1'b1, 8'h0c, $random(seed));
    ahb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    for (int k = 0; k < 4; k++) begin
      strap_a <= k[1];
      strap_b <= k[0];
      cyc(6);
      chk(32'(mode), 32'(mtab[k]));
    end
    strap_a <= 1'b0;
    strap_b <= 1'b1;
    cyc(6);
    chk(32'(btl), 32'(cfg_strap == PSPC_CFG_BTL));
    ahb(1'b1, PSPC_REG_CTRL, 32'h3);
    wait_rst(1'b1);
    cyc(10);
    chk(32'(drv), 32'h3);
    chk(32'({gh, gl}), 32'(pwm_seen));
    cfg_strap <= 1'b1;
    cyc(6);
    chk({30'h0, btl, drv[0]}, 32'h0);
    cfg_strap <= 1'b0;
    ow <= 1'b1;
    cyc(8);
    chk({30'h0, link.thermal_warn_n, link.fault_report_n}, m_pins[6]);
    chk(32'(drv), 32'h3);
    ahb(1'b0, PSPC_REG_MODE, 32'h0);
    chk(rd, m_pins[6]);
    ow <= 1'b0;
    cyc(6);
    chk({30'h0, link.thermal_warn_n, link.fault_report_n}, m_pins[7]);
    // each error source in turn, latched until reset toggles
    for (int k = 0; k < 6; k++) begin
      {ot_err, uv, ovc} <= 6'h1 << k;
      cyc(8 + ($random(seed) & 3));
      chk(32'({gh, gl, drv}), 32'h0);
      chk({30'h0, link.thermal_warn_n, link.fault_report_n}, m_pins[k]);
      ahb(1'b0, PSPC_REG_STATUS, 32'h0);
      chk(rd & 32'h37, {26'h0, PSPC_RUN, 2'h1, k == 5, 1'b1});
      {ot_err, uv, ovc} <= 6'h0;
      cyc(8);
      chk(32'(drv), 32'h0);
      ahb(1'b1, PSPC_REG_CTRL, 32'h0);
      wait_rst(1'b0);
      cyc(6);
      chk({30'h0, latch, link.fault_report_n}, 32'h1);
      chk(32'(drv), 32'h0);
      ahb(1'b1, PSPC_REG_CTRL, 32'h3);
      wait_rst(1'b1);
      cyc(10);
      chk(32'(drv), 32'h3);
      chk(32'({gh, gl}), 32'(pwm_seen));
    end
    // autorecovery, error on the second bridge
    strap_b <= 1'b0;
    cyc(6);
    // start the fault just after a pwm rise so no rise goes uncounted
    wait_rise();
    ovc <= 4'h4;
    cyc(8);
    ovc <= 4'h0;
    count_until(0);
    chk(32'(edges), 32'(PSPC_RCV_HALF));
    chk(32'(drv), 32'h0);
    count_until(1);
    chk(32'(edges), 32'(PSPC_RCV_FULL));
    strap_a <= 1'b1;
    strap_b <= 1'b1;
    cyc(6);
    ovc <= 4'h2;
    cyc(8);
    chk({29'h0, link.fault_report_n, drv}, 32'h7);
    ovc <= 4'h0;
    ahb(1'b1, PSPC_REG_CTRL, 32'h0);
    wait_rst(1'b0);
    cyc(4);
    report_and_stop();
  end
endmodule
`default_nettype wire
